// >>> src/bmc_pkg.sv
// constants, types and the led pattern table for the button and led mode controller
// assumes a 20 MHz clock and a 50 ms timebase tick
package bmc_pkg;
    // -----------------------------------------------------------------
    // timebase
    // -----------------------------------------------------------------
    localparam int CLK_NS = 50;
    localparam int TICK_NS = 50_000_000;
    localparam int TICK_CYCLES = TICK_NS / CLK_NS;

    // -----------------------------------------------------------------
    // durations in 50 ms ticks
    // -----------------------------------------------------------------
    localparam logic [8:0] T_FL = 9'h002;
    localparam logic [8:0] T_Q4OFF = 9'h003;
    localparam logic [8:0] T_HALF = 9'h00a;
    localparam logic [8:0] T_FAULT_REST = 9'h00e;
    localparam logic [8:0] T_1S = 9'h014;
    localparam logic [8:0] T_3S = 9'h03c;
    localparam logic [8:0] T_HOLD_CYC = 9'h050;
    localparam logic [8:0] T_5S = 9'h064;
    localparam logic [8:0] T_7S = 9'h08c;
    localparam logic [8:0] T_10S = 9'h0c8;
    localparam logic [8:0] T_11S = 9'h0dc;
    localparam logic [8:0] T_MAX = 9'h1ff;
    localparam logic [10:0] T_MIN = 11'h4b0;
    localparam logic [3:0] FAST_LAST = 4'he;

    // -----------------------------------------------------------------
    // press counts and pattern steps
    // -----------------------------------------------------------------
    localparam logic [1:0] N_ONE = 2'h1;
    localparam logic [1:0] N_TWO = 2'h2;
    localparam logic [1:0] N_THREE = 2'h3;
    localparam logic [3:0] LINK_LOOP_STEP = 4'h1;
    localparam logic [3:0] LINK_Q_LAST = 4'h9;

    // -----------------------------------------------------------------
    // types
    // -----------------------------------------------------------------
    typedef enum logic [2:0] {P_NONE, P_ON10, P_BLINK1, P_BLINK2, P_TWO, P_FAULT, P_WAKE, P_LINK} bmc_pat_t;
    typedef struct packed {logic link_ok; logic fault;} bmc_stat_t;
    typedef struct packed {logic therm; logic digital; logic contact; logic cfg_req;} bmc_probe_t;
    typedef struct packed {logic therm_en; logic digital_en; logic contact_en; logic cfg_en; logic conflict;} bmc_port_t;
    typedef struct packed {logic tx_now; logic link_restart; logic wake; logic fw_reset; logic sleep_enter;} bmc_evt_t;
    typedef struct packed {logic on; logic [8:0] len; logic last;} bmc_seg_t;

    // led segment for a pattern and step
    function automatic bmc_seg_t seg_of(input bmc_pat_t p, input logic [3:0] s);
        bmc_seg_t r;
        r = '{on: 1'b0, len: T_FL, last: 1'b1};
        case (p)
            P_ON10: r = '{on: 1'b1, len: T_10S, last: 1'b1};
            P_BLINK1: r = (s == 4'h0) ? bmc_seg_t'{1'b0, T_1S, 1'b0} : bmc_seg_t'{1'b1, T_FL, 1'b1};
            P_BLINK2: r = (s == 4'h0) ? bmc_seg_t'{1'b0, T_1S, 1'b0} : bmc_seg_t'{s[0], T_FL, s == 4'h3};
            P_TWO: r = '{~s[0], T_FL, s == 4'h2};
            P_FAULT: r = (s == 4'h3) ? bmc_seg_t'{1'b0, T_FAULT_REST, 1'b1} : bmc_seg_t'{~s[0], T_FL, 1'b0};
            P_WAKE: begin
                case (s)
                    4'h0: r = '{1'b1, T_3S, 1'b0};
                    4'h1: r = '{1'b0, T_FL, 1'b0};
                    4'h2: r = '{1'b1, T_HALF, 1'b0};
                    4'h3: r = '{1'b0, T_1S, 1'b0};
                    4'h4: r = '{1'b1, T_FL, 1'b0};
                    4'h5: r = '{1'b0, T_HALF, 1'b0};
                    default: r = '{1'b1, T_FL, 1'b1};
                endcase
            end
            P_LINK: begin
                if (s == 4'h0) r = '{1'b1, T_FL, 1'b0};
                else if (s == LINK_LOOP_STEP) r = '{1'b0, T_1S - T_FL, 1'b0};
                else if (s <= LINK_Q_LAST) r = '{~s[0], s[0] ? T_Q4OFF : T_FL, 1'b0};
                else r = '{1'b1, T_10S, 1'b1};
            end
            default: r = '{on: 1'b0, len: T_FL, last: 1'b1};
        endcase
        return r;
    endfunction
endpackage

// >>> src/bmc_top.sv
// button and led mode controller: press decoding, led patterns, mode events, probe port gating
// assumes button and state inputs are synchronous to clock; firmware acts on the event pulses
// Notes on behaviour
// RULE1: linked idle run mode keeps led dark
// RULE2: short single press linked lights led 10s
// RULE3: fault repeats two quick flashes every second
// RULE4: broken link query: lit held, one flash
// RULE5: sleep query: lit held, two flashes later
// RULE6: linked double press starts fifteen minute fast transmit
// RULE7: broken double press restarts link, shows progress
// RULE8: three presses in sleep wake unit
// RULE9: hold seven to eleven seconds resets firmware
// RULE10: hold beyond eleven seconds enters deep sleep
// RULE11: thermistor and digital probe never both enabled
// RULE12: contact input and configuration share one port
// RULE13: fast transmit end returns normal interval
// RULE14: double press in fast mode restarts period
// RULE15: debounce on timebase; mid holds ignored
// RULE16: press count settles after window closes
`timescale 1ns/10ps
module bmc_top #(
    parameter int TICK_CYCLES = bmc_pkg::TICK_CYCLES
) (
    // clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // push button, high while pressed
    input wire logic button,
    // unit and probe state
    input wire bmc_pkg::bmc_stat_t stat,
    input wire bmc_pkg::bmc_probe_t probe,
    // indicator and modes
    output logic led,
    output logic fast_tx,
    output logic asleep,
    // event pulses and port enables
    output bmc_pkg::bmc_evt_t evt,
    output bmc_pkg::bmc_port_t ports
);
    // -----------------------------------------------------------------
    // timebase and debounce
    // -----------------------------------------------------------------
    logic [19:0] tick_cnt;
    logic samp;
    logic pressed;
    logic pressed_d;
    wire tick = tick_cnt == 20'(TICK_CYCLES - 1);
    wire rise = pressed & ~pressed_d;
    wire fall = ~pressed & pressed_d;

    always_ff @(posedge clock) begin
        if (sys_rst || tick) begin
            tick_cnt <= '0;
        end else begin
            tick_cnt <= tick_cnt + 20'h0_0001;
        end
    end

    // a level must be seen on two ticks in a row to count
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            samp <= 1'b0;
            pressed <= 1'b0;
            pressed_d <= 1'b0;
        end else begin
            pressed_d <= pressed;
            if (tick) begin
                samp <= button;
                if (samp == button) begin
                    pressed <= button; // [RULE15]
                end
            end
        end
    end

    // -----------------------------------------------------------------
    // hold timing
    // -----------------------------------------------------------------
    logic [8:0] hold_t;
    logic [8:0] ph;
    wire hold_led = ph < bmc_pkg::T_3S;
    wire short_rel = fall && hold_t < bmc_pkg::T_3S;
    wire fw_rel = fall && hold_t > bmc_pkg::T_7S && hold_t <= bmc_pkg::T_11S; // [RULE9]
    wire sleep_rel = fall && hold_t > bmc_pkg::T_11S; // [RULE10]

    always_ff @(posedge clock) begin
        if (sys_rst || rise) begin
            hold_t <= '0;
            ph <= '0;
        end else if (pressed && tick) begin
            hold_t <= (hold_t == bmc_pkg::T_MAX) ? hold_t : hold_t + 9'h001;
            ph <= (ph == bmc_pkg::T_HOLD_CYC - 9'h001) ? '0 : ph + 9'h001;
        end
    end

    // -----------------------------------------------------------------
    // press counting window
    // -----------------------------------------------------------------
    logic win_on;
    logic [8:0] win_t;
    logic [1:0] pcount;
    wire [8:0] win_len = asleep ? bmc_pkg::T_5S : bmc_pkg::T_1S;
    wire settle = win_on && !pressed && tick && win_t >= win_len; // [RULE16]

    always_ff @(posedge clock) begin
        if (sys_rst || settle || (fall && !short_rel)) begin
            win_on <= 1'b0;
            win_t <= '0;
            pcount <= '0; // [RULE15]
        end else begin
            if (rise && !win_on) begin
                win_on <= 1'b1;
                win_t <= '0;
            end else if (win_on && tick && win_t != bmc_pkg::T_MAX) begin
                win_t <= win_t + 9'h001;
            end
            if (short_rel && pcount != bmc_pkg::N_THREE) begin
                pcount <= pcount + 2'h1;
            end
        end
    end

    // -----------------------------------------------------------------
    // request decode
    // -----------------------------------------------------------------
    logic [10:0] min_t;
    logic [3:0] mins;
    wire run = settle && !asleep && stat.link_ok;
    wire broken = settle && !asleep && !stat.link_ok;
    wire q_run = run && pcount == bmc_pkg::N_ONE; // [RULE2]
    wire fast_req = run && pcount == bmc_pkg::N_TWO; // [RULE6] [RULE14]
    wire q_broken = broken && pcount == bmc_pkg::N_ONE; // [RULE4]
    wire relink_req = broken && pcount == bmc_pkg::N_TWO; // [RULE7]
    wire q_sleep = settle && asleep && pcount == bmc_pkg::N_ONE; // [RULE5]
    wire wake_req = settle && asleep && pcount == bmc_pkg::N_THREE; // [RULE8]
    wire minute_end = fast_tx && tick && min_t == bmc_pkg::T_MIN - 11'h001;
    wire fast_end = minute_end && mins == bmc_pkg::FAST_LAST; // [RULE13]
    bmc_pkg::bmc_evt_t next_evt;
    assign next_evt = '{tx_now: minute_end, link_restart: relink_req, wake: wake_req,
                        fw_reset: fw_rel, sleep_enter: sleep_rel};

    // -----------------------------------------------------------------
    // modes and events
    // -----------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            evt <= '0;
            asleep <= 1'b0;
        end else begin
            evt <= next_evt;
            asleep <= wake_req ? 1'b0 : (sleep_rel | asleep);
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            fast_tx <= 1'b0;
            min_t <= '0;
            mins <= '0;
        end else if (fast_req) begin
            fast_tx <= 1'b1; // [RULE6] [RULE14]
            min_t <= '0;
            mins <= '0;
        end else if (fast_end) begin
            fast_tx <= 1'b0; // [RULE13]
        end else if (minute_end) begin
            min_t <= '0;
            mins <= mins + 4'h1;
        end else if (fast_tx && tick) begin
            min_t <= min_t + 11'h001;
        end
    end

    // -----------------------------------------------------------------
    // led pattern player
    // -----------------------------------------------------------------
    bmc_pkg::bmc_pat_t pat;
    bmc_pkg::bmc_pat_t start_pat;
    logic [3:0] step;
    logic [8:0] seg_t;
    bmc_pkg::bmc_seg_t seg;
    assign seg = bmc_pkg::seg_of(pat, step);
    assign start_pat = wake_req ? bmc_pkg::P_WAKE : // [RULE8]
                       (sleep_rel || fw_rel) ? bmc_pkg::P_TWO : // [RULE9] [RULE10]
                       relink_req ? bmc_pkg::P_LINK : // [RULE7]
                       q_broken ? bmc_pkg::P_BLINK1 : // [RULE4]
                       q_sleep ? bmc_pkg::P_BLINK2 : // [RULE5]
                       (q_run || fast_req) ? bmc_pkg::P_ON10 : bmc_pkg::P_NONE; // [RULE2] [RULE6]
    wire start = start_pat != bmc_pkg::P_NONE;
    wire idle = pat == bmc_pkg::P_NONE;
    wire auto_fault = idle && stat.fault && !asleep && !pressed; // [RULE3]
    wire seg_done = tick && !idle && seg_t + 9'h001 >= seg.len;
    // the link pattern keeps blinking once a second until the link is up
    wire link_loop = pat == bmc_pkg::P_LINK && step == bmc_pkg::LINK_LOOP_STEP && !stat.link_ok; // [RULE7]
    wire next_led = pressed ? hold_led : (!idle && seg.on); // [RULE1] [RULE4] [RULE5] [RULE9] [RULE10]

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            pat <= bmc_pkg::P_NONE;
            step <= '0;
            seg_t <= '0;
        end else if (start || auto_fault) begin
            pat <= start ? start_pat : bmc_pkg::P_FAULT;
            step <= '0;
            seg_t <= '0;
        end else if (seg_done) begin
            seg_t <= '0;
            step <= link_loop ? 4'h0 : step + 4'h1;
            if (seg.last) begin
                pat <= bmc_pkg::P_NONE;
            end
        end else if (tick && !idle) begin
            seg_t <= seg_t + 9'h001;
        end
    end

    // -----------------------------------------------------------------
    // led and probe port enables
    // -----------------------------------------------------------------
    bmc_pkg::bmc_port_t next_ports;
    assign next_ports = '{therm_en: probe.therm,
                          digital_en: probe.digital & ~probe.therm, // [RULE11]
                          contact_en: probe.contact & ~probe.cfg_req, // [RULE12]
                          cfg_en: probe.cfg_req & ~probe.contact, // [RULE12]
                          conflict: probe.therm & probe.digital};

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            led <= 1'b0;
            ports <= '0;
        end else begin
            led <= next_led;
            ports <= next_ports;
        end
    end

    // -----------------------------------------------------------------
    // checks
    // -----------------------------------------------------------------
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (sys_rst);

    sequence s_wake;
        wake_req ##1 (evt.wake && !asleep);
    endsequence
    sequence s_deep;
        sleep_rel ##1 (evt.sleep_enter && asleep);
    endsequence

    property p_dark;
        idle && !pressed && !stat.fault && stat.link_ok |=> !led;
    endproperty
    a_dark: assert property (p_dark) else $error("led lit in linked idle run"); // [RULE1]
    property p_query_run;
        q_run |=> pat == bmc_pkg::P_ON10 ##1 (led || pressed);
    endproperty
    a_query_run: assert property (p_query_run) else $error("query did not light led"); // [RULE2]
    property p_fault;
        auto_fault && !start |=> pat == bmc_pkg::P_FAULT && step == 4'h0;
    endproperty
    a_fault: assert property (p_fault) else $error("fault pattern not started"); // [RULE3]
    property p_broken;
        q_broken |=> pat == bmc_pkg::P_BLINK1 ##1 (pressed || !led);
    endproperty
    a_broken: assert property (p_broken) else $error("broken query pattern wrong"); // [RULE4]
    property p_sleep_q;
        q_sleep |=> pat == bmc_pkg::P_BLINK2 && asleep;
    endproperty
    a_sleep_q: assert property (p_sleep_q) else $error("sleep query pattern wrong"); // [RULE5]
    property p_fast;
        fast_req |=> fast_tx && mins == '0 && min_t == '0 && pat == bmc_pkg::P_ON10;
    endproperty
    a_fast: assert property (p_fast) else $error("fast transmit not (re)started"); // [RULE6] [RULE14]
    property p_relink;
        relink_req |=> evt.link_restart && pat == bmc_pkg::P_LINK;
    endproperty
    a_relink: assert property (p_relink) else $error("link restart missing"); // [RULE7]
    property p_loop;
        seg_done && link_loop && !start |=> pat == bmc_pkg::P_LINK && step == 4'h0;
    endproperty
    a_loop: assert property (p_loop) else $error("link wait did not loop"); // [RULE7]
    property p_wake;
        s_wake |-> pat == bmc_pkg::P_WAKE && step == 4'h0;
    endproperty
    a_wake: assert property (p_wake) else $error("wake sequence wrong"); // [RULE8]
    property p_fw;
        fw_rel |=> evt.fw_reset && !evt.sleep_enter && pat == bmc_pkg::P_TWO;
    endproperty
    a_fw: assert property (p_fw) else $error("firmware reset not issued"); // [RULE9]
    property p_deep;
        s_deep |=> !evt.sleep_enter && pat == bmc_pkg::P_TWO;
    endproperty
    a_deep: assert property (p_deep) else $error("deep sleep entry wrong"); // [RULE10]
    property p_probe;
        ports.therm_en |-> !ports.digital_en;
    endproperty
    a_probe: assert property (p_probe) else $error("both probes enabled"); // [RULE11]
    property p_share;
        !(ports.contact_en && ports.cfg_en);
    endproperty
    a_share: assert property (p_share) else $error("shared port double use"); // [RULE12]
    property p_fast_end;
        fast_end && !fast_req |=> !fast_tx && evt.tx_now;
    endproperty
    a_fast_end: assert property (p_fast_end) else $error("fast mode did not end"); // [RULE13]
    property p_debounce;
        $changed(pressed) |-> $past(tick);
    endproperty
    a_debounce: assert property (p_debounce) else $error("press changed off tick"); // [RULE15]
    property p_ignore;
        fall && hold_t >= bmc_pkg::T_3S && hold_t <= bmc_pkg::T_7S |=> !evt.fw_reset && !evt.sleep_enter && pcount == '0;
    endproperty
    a_ignore: assert property (p_ignore) else $error("mid hold acted on"); // [RULE15]
    property p_settle;
        settle |-> win_t >= bmc_pkg::T_1S && !pressed && win_on;
    endproperty
    a_settle: assert property (p_settle) else $error("count settled early"); // [RULE16]
endmodule

// >>> bench/bmc_person.sv
// model of the person at the button: presses for set times and watches the led
// assumes the design samples the button on its own timebase ticks of TC clocks
`timescale 1ns/10ps
module bmc_person #(
    parameter int TC = 2
) (
    // clock
    input wire logic clock,
    // what the person sees and pushes
    input wire logic led,
    output logic button
);
    initial button = 1'b0;

    // -----------------------------------------------------------------
    // button
    // -----------------------------------------------------------------
    // held level for whole ticks, so the debounce sees two agreeing samples
    task automatic press(input int hold, input int gap);
        @(posedge clock);
        button <= 1'b1;
        repeat (hold * TC) @(posedge clock);
        button <= 1'b0;
        repeat (gap * TC) @(posedge clock);
    endtask

    // -----------------------------------------------------------------
    // eyes on the led
    // -----------------------------------------------------------------
    task automatic count_rises(input int ticks, output int n);
        logic prev;
        n = 0;
        prev = led;
        repeat (ticks * TC) begin
            @(posedge clock);
            if (led === 1'b1 && prev !== 1'b1) n++;
            prev = led;
        end
    endtask

    // waits for a dark led, then a lit one, and returns how long it stays lit
    task automatic high_run(input int bound, output int len);
        int k;
        len = 0;
        k = 0;
        while (led === 1'b1 && k < bound * TC) begin
            @(posedge clock);
            k++;
        end
        while (led !== 1'b1 && k < bound * TC) begin
            @(posedge clock);
            k++;
        end
        while (led === 1'b1 && len < 500 * TC) begin
            @(posedge clock);
            len++;
        end
    endtask
endmodule

// >>> bench/bmc_top_tb.sv
// self-checking bench for the button and led mode controller
// assumes a shortened timebase of TC clocks per tick; the person model drives the button
`timescale 1ns/10ps
module bmc_top_tb;
    localparam int TC = 2;
    logic clock;
    logic sys_rst;
    logic button;
    logic led;
    logic fast_tx;
    logic asleep;
    bmc_pkg::bmc_stat_t stat;
    bmc_pkg::bmc_probe_t probe;
    bmc_pkg::bmc_evt_t evt;
    bmc_pkg::bmc_port_t ports;
    bmc_pkg::bmc_port_t pexp;
    int mismatches = 0;
    int n_checks = 0;
    int n_tx = 0;
    int n_lr = 0;
    int n_wk = 0;
    int n_fw = 0;
    int n_sl = 0;
    int b_tx, b_fw, b_sl, n, len, k, h;
    integer seed = 32'h9614;

    bmc_top #(.TICK_CYCLES(TC)) bmc_top_inst (.clock(clock), .sys_rst(sys_rst), .button(button), .stat(stat),
        .probe(probe), .led(led), .fast_tx(fast_tx), .asleep(asleep), .evt(evt), .ports(ports));
    bmc_person #(.TC(TC)) bmc_person_inst (.clock(clock), .led(led), .button(button));

    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    // -----------------------------------------------------------------
    // event pulse counters
    // -----------------------------------------------------------------
    always @(posedge clock) begin
        if (evt.tx_now === 1'b1) n_tx <= n_tx + 1;
        if (evt.link_restart === 1'b1) n_lr <= n_lr + 1;
        if (evt.wake === 1'b1) n_wk <= n_wk + 1;
        if (evt.fw_reset === 1'b1) n_fw <= n_fw + 1;
        if (evt.sleep_enter === 1'b1) n_sl <= n_sl + 1;
    end

    // -----------------------------------------------------------------
    // checking helpers
    // -----------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] lo, input logic [31:0] hi, input logic [31:0] got);
        n_checks++;
        if ((got >= lo && got <= hi) !== 1'b1) begin
            mismatches++;
            $display("wrong value %s expected %0d..%0d seen %0d", what, lo, hi, got);
        end
    endtask

    function automatic bmc_pkg::bmc_port_t port_exp(input bmc_pkg::bmc_probe_t p);
        return '{therm_en: p.therm, digital_en: p.digital & ~p.therm, contact_en: p.contact & ~p.cfg_req,
            cfg_en: p.cfg_req & ~p.contact, conflict: p.therm & p.digital};
    endfunction

    task automatic ticks(input int t);
        repeat (t * TC) @(posedge clock);
    endtask

    task automatic print_verdict();
        if (mismatches == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // -----------------------------------------------------------------
    // main sequence
    // -----------------------------------------------------------------
    initial begin
        sys_rst = 1'b1;
        stat = '{link_ok: 1'b1, fault: 1'b0};
        probe = 4'h0;
        repeat (5) @(posedge clock);
        sys_rst <= 1'b0;
        @(posedge clock);
        chk("outputs after reset", 0, 0, {led, fast_tx, asleep, evt});
        bmc_person_inst.count_rises(100, n);
        chk("idle rises", 0, 0, n);
        for (k = 0; k < 24; k++) begin
            probe <= (k < 16) ? k[3:0] : 4'($random(seed));
            repeat (3) @(posedge clock);
            pexp = port_exp(probe);
            chk("ports", pexp, pexp, ports);
        end
        for (k = 0; k < 2; k++) begin
            h = 2 + ($random(seed) & 7);
            bmc_person_inst.press(h, 0);
            bmc_person_inst.high_run(60, len);
            chk("query on time", 199 * TC, 201 * TC, len);
            chk("no fast after single", 0, 0, fast_tx);
            ticks(20);
        end
        b_fw = n_fw;
        b_sl = n_sl;
        bmc_person_inst.press(100, 60);
        chk("mid hold events", 0, 0, (n_fw - b_fw) + (n_sl - b_sl) + asleep);
        // the hold pattern lights for 60 of every 80 ticks, so a 160 tick hold shows two rises
        fork
            bmc_person_inst.press(160, 60);
            bmc_person_inst.count_rises(160, n);
        join
        chk("fw hold led cycles", 2, 2, n);
        chk("fw reset pulses", 1, 1, n_fw - b_fw);
        chk("sleep after fw hold", 0, 0, (n_sl - b_sl) + asleep);
        stat.link_ok <= 1'b0;
        ticks(5);
        bmc_person_inst.press(5, 0);
        bmc_person_inst.count_rises(60, n);
        chk("broken query flashes", 1, 1, n);
        b_tx = n_lr;
        bmc_person_inst.press(3, 3);
        bmc_person_inst.press(3, 20);
        chk("link restart pulses", 1, 1, n_lr - b_tx);
        bmc_person_inst.count_rises(60, n);
        chk("link wait flashes", 2, 4, n);
        stat.link_ok <= 1'b1;
        len = 0;
        for (k = 0; k < 8 && len < 100 * TC; k++) bmc_person_inst.high_run(60, len);
        chk("linked on time", 199 * TC, 201 * TC, len);
        chk("quick flashes", 5, 6, k);
        stat <= '{link_ok: 1'b1, fault: 1'b1};
        ticks(5);
        bmc_person_inst.count_rises(100, n);
        chk("fault flashes", 9, 11, n);
        stat.fault <= 1'b0;
        ticks(40);
        bmc_person_inst.press(230, 40);
        chk("sleep pulses", 1, 1, n_sl - b_sl);
        chk("asleep", 1, 1, asleep);
        ticks(100);
        bmc_person_inst.press(5, 0);
        // asleep the count window is five seconds long, so the flashes come late
        bmc_person_inst.count_rises(160, n);
        chk("sleep query flashes", 2, 2, n);
        ticks(100);
        b_tx = n_wk;
        repeat (3) bmc_person_inst.press(3, 5);
        bmc_person_inst.high_run(200, len);
        chk("wake first on", 59 * TC, 61 * TC, len);
        chk("wake pulses", 1, 1, n_wk - b_tx);
        chk("awake", 0, 0, asleep);
        ticks(100);
        bmc_person_inst.press(3, 3);
        bmc_person_inst.press(3, 0);
        bmc_person_inst.high_run(60, len);
        chk("fast on time", 199 * TC, 201 * TC, len);
        chk("fast mode", 1, 1, fast_tx);
        b_tx = n_tx;
        for (k = 0; k < 1300 * TC && n_tx == b_tx; k++) @(posedge clock);
        chk("first minute send", 1, 1, n_tx - b_tx);
        bmc_person_inst.press(3, 3);
        bmc_person_inst.press(3, 0);
        b_tx = n_tx;
        for (k = 0; k < 16 * 1200 * TC && fast_tx === 1'b1; k++) @(posedge clock);
        @(posedge clock);
        chk("sends after restart", 15, 15, n_tx - b_tx);
        chk("fast mode over", 0, 0, fast_tx);
        b_tx = n_tx;
        ticks(1300);
        chk("no fast sends after", 0, 0, n_tx - b_tx);
        print_verdict();
    end
endmodule
